// [design/pms_pkg.sv]
// Package of constants and types for the power mode sequencer
`default_nettype none
package pms_pkg;
   // ------------------------------------------------------------
   // Register byte addresses on the APB
   // ------------------------------------------------------------
   localparam logic [7:0] PMS_POWCTL_ADDR = 8'hc5; // Power control
   localparam logic [7:0] PMS_PERCFG_ADDR = 8'hf4; // Peripheral config
   localparam logic [7:0] PMS_WAKE_ADDR = 8'h40; // Wake selections
   localparam logic [7:0] PMS_SWO_ADDR = 8'h44; // Switchover control
   localparam logic [7:0] PMS_STAT_ADDR = 8'h48; // Mode and status
   localparam logic [7:0] PMS_SCR0_ADDR = 8'h50; // First scratch word
   localparam logic [7:0] PMS_LCD_ADDR = 8'h60; // Display control
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int PMS_POW_SLEEP_BIT = 4; // Power control sleep request
   localparam int PMS_POW_SWRST_BIT = 0; // Software reset request
   localparam int PMS_PER_SRC_BIT = 6; // Rail on main supply
   localparam int PMS_PER_RXF_BIT = 7; // Receive edge flag
   localparam int PMS_WK_A_BIT = 0; // Ext A wake select
   localparam int PMS_WK_AEDGE_BIT = 1; // Ext A edge type
   localparam int PMS_WK_B_LSB = 2; // Ext B select, 3 bits
   localparam int PMS_WK_BEDGE_BIT = 5; // Ext B edge type
   localparam int PMS_WK_RX_LSB = 6; // Receive select, 2 bits
   localparam int PMS_SWO_LOWVDD_BIT = 0; // Switch on low main supply
   localparam int PMS_SWO_LOWDC_BIT = 1; // Switch on low DC input
   localparam int PMS_NSCRATCH = 4; // Retained scratch words
   localparam logic [2:0] PMS_B_WAKE_SEL = 3'b110; // Upper two bits
   localparam logic [1:0] PMS_RX_WAKE_SEL = 2'b11;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int PMS_CLK_HZ = 25000000;
   localparam int PMS_LOWDC_DELAY_MS = 30; // Low DC input to switchover
   localparam int PMS_LOWDC_CYCLES = (PMS_CLK_HZ / 1000) * PMS_LOWDC_DELAY_MS;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PMS_FULL, PMS_BATT, PMS_SLEEP
   } pms_mode_t;
   // Supply side status travelling together
   typedef struct packed {
      logic main_ok; // Main supply good
      logic dc_low; // Low DC input seen
   } pms_supply_t;
endpackage : pms_pkg
`default_nettype wire

// [design/pms_sync.sv]
// Two flop synchroniser bank for pin inputs
`default_nettype none
module pms_sync #(
   parameter int WIDTH = 1,
   // Reset value per bit, set to the pin's idle level
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by q

   // Elaboration check: an empty bank cannot be built
   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one");
   end

   // ------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------
   // Two stages per bit, no logic between
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : pms_sync
`default_nettype wire

// [design/pms_sequencer.sv]
// Power mode sequencer with APB registers and wake logic
//
// Summary of operation
// - Ext A wake on selected edge
// - Ext B wake when select is 11x
// - Receive edge in sleep sets flag and wakes
// - Reset pin low in sleep wakes battery
// - Display driver enable kept through sleep
// - Four scratch registers kept in sleep
// - Switchover moves to battery, front end off
// - Sleep bit in battery stops core
// - Battery wake restarts at reset vector
// - Supply back in sleep restarts core, front end
// - Supply back in battery restarts front end only
// - Software reset restarts at reset vector
// - Peripheral config bit 6 shows main supply
// - Low DC switchover completes 30 ms later
// - Supply return is unmaskable wake
//
// Chosen here: the APB interface to the registers and the register addresses.
`default_nettype none
module pms_sequencer #(
   parameter int LOWDC_CYCLES = pms_pkg::PMS_LOWDC_CYCLES
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins, asynchronous
   input wire logic ext_irq_a_n,
   input wire logic ext_irq_b_n,
   input wire logic rx_line,
   input wire logic ext_reset_n,
   // Supply switchover circuitry, asynchronous
   input wire logic main_supply_ok,
   input wire logic dc_input_low,
   output logic rail_to_battery,
   // Core and front end control
   output logic core_run,
   output logic core_reset,
   output logic afe_enable,
   output logic lcd_enable,
   output logic [1:0] mode
);
   // Elaboration check: the timer needs at least one cycle
   if (LOWDC_CYCLES < 1) begin : g_bad_lowdc
      $error("LOWDC_CYCLES must be at least one");
   end

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   logic [5:0] pin_s; // Synchronised pins
   // Reset to idle levels: no false edge or supply loss after reset
   pms_sync #(.WIDTH(6), .RST_VAL(6'h1f)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({dc_input_low, main_supply_ok, ext_reset_n, rx_line,
          ext_irq_b_n, ext_irq_a_n}),
      .q(pin_s)
   );
   pms_pkg::pms_supply_t sup; // Supply status bundle
   // Main supply good first, low DC input second
   assign sup = {pin_s[4], pin_s[5]};

   // ------------------------------------------------------------
   // Register and state storage
   // ------------------------------------------------------------
   pms_pkg::pms_mode_t mode_r, mode_nxt; // Operating mode
   logic [7:0] wake_r, wake_nxt; // Wake selections and edges
   logic [1:0] swo_r, swo_nxt; // Switchover enables
   logic rxf_r, rxf_nxt; // Receive edge flag
   logic lcd_r, lcd_nxt; // Display driver enable
   logic [31:0] scr_r [pms_pkg::PMS_NSCRATCH]; // Retained scratch
   logic [31:0] scr_nxt [pms_pkg::PMS_NSCRATCH];
   logic [3:0] prev_r; // Last pin levels: rst, rx, b, a
   logic [31:0] dc_cnt_r, dc_cnt_nxt; // Low DC switchover timer
   logic core_run_r, core_run_nxt;
   logic core_rst_r, core_rst_nxt;
   logic afe_r, afe_nxt;
   logic batt_r, batt_nxt; // Rail on battery
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic pready_r, pready_nxt;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic wr_go, rd_go; // Access phase strobes
   logic [7:0] wdat; // Low byte of write data
   assign wr_go = psel && penable && pwrite && pready_r;
   assign rd_go = psel && penable && !pwrite && pready_r;
   assign wdat = pwdata[7:0];

   // ------------------------------------------------------------
   // Wake detection
   // ------------------------------------------------------------
   logic a_edge, b_edge, rx_edge, rst_fall; // Pin events
   logic wake_a, wake_b, wake_rx; // Enabled wake sources
   logic a_fall, a_rise, b_fall, b_rise;
   always_comb begin
      a_fall = prev_r[0] && !pin_s[0];
      a_rise = !prev_r[0] && pin_s[0];
      b_fall = prev_r[1] && !pin_s[1];
      b_rise = !prev_r[1] && pin_s[1];
      // Edge bit set picks falling edge, clear picks rising
      a_edge = wake_r[pms_pkg::PMS_WK_AEDGE_BIT] ? a_fall : a_rise;
      b_edge = wake_r[pms_pkg::PMS_WK_BEDGE_BIT] ? b_fall : b_rise;
      rx_edge = prev_r[2] != pin_s[2];
      rst_fall = prev_r[3] && !pin_s[3];
      // Ext A and B pending flags live in the core; only the wake is raised here
      wake_a = wake_r[pms_pkg::PMS_WK_A_BIT] && a_edge;
      wake_b = (wake_r[pms_pkg::PMS_WK_B_LSB+1 +: 2] ==
                pms_pkg::PMS_B_WAKE_SEL[2:1]) && b_edge;
      wake_rx = (wake_r[pms_pkg::PMS_WK_RX_LSB +: 2] ==
                 pms_pkg::PMS_RX_WAKE_SEL) && rx_edge;
   end

   // ------------------------------------------------------------
   // Next state: mode sequencing and registers
   // ------------------------------------------------------------
   logic sleep_req, swrst_req, swo_event, dc_done;
   always_comb begin
      mode_nxt = mode_r;
      wake_nxt = wake_r;
      swo_nxt = swo_r;
      rxf_nxt = rxf_r;
      lcd_nxt = lcd_r;
      scr_nxt = scr_r;
      dc_cnt_nxt = dc_cnt_r;
      core_run_nxt = core_run_r;
      core_rst_nxt = 1'b0; // Reset request lasts one cycle
      afe_nxt = afe_r;
      batt_nxt = batt_r;
      sleep_req = wr_go && (paddr == pms_pkg::PMS_POWCTL_ADDR) &&
                  wdat[pms_pkg::PMS_POW_SLEEP_BIT];
      swrst_req = wr_go && (paddr == pms_pkg::PMS_POWCTL_ADDR) &&
                  wdat[pms_pkg::PMS_POW_SWRST_BIT];
      // Low DC timer counts while enabled and condition present
      dc_done = 1'b0;
      if (swo_r[pms_pkg::PMS_SWO_LOWDC_BIT] && sup.dc_low) begin
         if (dc_cnt_r == 32'(LOWDC_CYCLES - 1)) begin
            dc_done = 1'b1;
         end else begin
            dc_cnt_nxt = dc_cnt_r + 32'h0000_0001;
         end
      end else begin
         dc_cnt_nxt = '0;
      end
      swo_event = (swo_r[pms_pkg::PMS_SWO_LOWVDD_BIT] && !sup.main_ok) ||
                  dc_done;
      // Register writes; registers survive sleep untouched
      if (wr_go) begin
         case (paddr)
            pms_pkg::PMS_WAKE_ADDR: wake_nxt = wdat;
            pms_pkg::PMS_SWO_ADDR: swo_nxt = wdat[1:0];
            pms_pkg::PMS_LCD_ADDR: lcd_nxt = wdat[0];
            pms_pkg::PMS_PERCFG_ADDR: begin
               // Writing one clears the receive flag
               if (wdat[pms_pkg::PMS_PER_RXF_BIT]) rxf_nxt = 1'b0;
            end
            default: begin
               for (int i = 0; i < pms_pkg::PMS_NSCRATCH; i++) begin
                  if (paddr == pms_pkg::PMS_SCR0_ADDR + 8'(4 * i)) begin
                     scr_nxt[i] = pwdata;
                  end
               end
            end
         endcase
      end
      // Set beats clear on the receive flag
      if (mode_r == pms_pkg::PMS_SLEEP && wake_rx) rxf_nxt = 1'b1;
      // Mode machine
      case (mode_r)
         pms_pkg::PMS_FULL: begin
            if (swo_event) begin
               mode_nxt = pms_pkg::PMS_BATT;
               batt_nxt = 1'b1;
               afe_nxt = 1'b0;
            end else if (swrst_req) begin
               core_rst_nxt = 1'b1;
            end
         end
         pms_pkg::PMS_BATT: begin
            if (sup.main_ok && !swo_event) begin
               mode_nxt = pms_pkg::PMS_FULL;
               batt_nxt = 1'b0;
               afe_nxt = 1'b1;
            end else if (sleep_req) begin
               // Software is expected to clear wake flags first
               mode_nxt = pms_pkg::PMS_SLEEP;
               core_run_nxt = 1'b0;
            end else if (swrst_req) begin
               core_rst_nxt = 1'b1;
            end
         end
         pms_pkg::PMS_SLEEP: begin
            if (sup.main_ok && !swo_event) begin
               // Unmaskable supply restored wake
               mode_nxt = pms_pkg::PMS_FULL;
               batt_nxt = 1'b0;
               afe_nxt = 1'b1;
               core_run_nxt = 1'b1;
               core_rst_nxt = 1'b1;
            end else if (rst_fall || wake_a || wake_b || wake_rx) begin
               // Reset pin wake cannot be masked
               mode_nxt = pms_pkg::PMS_BATT;
               core_run_nxt = 1'b1;
               core_rst_nxt = 1'b1;
            end
         end
         default: begin
            mode_nxt = pms_pkg::PMS_FULL;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Read mux and bus answer
   // ------------------------------------------------------------
   always_comb begin
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      // One wait state: ready rises the cycle after the access begins
      pready_nxt = psel && penable && !pready_r;
      // Answer loads with ready, so it stands while ready is sampled
      if (pready_nxt) begin
         prdata_nxt = '0;
         case (paddr)
            pms_pkg::PMS_POWCTL_ADDR: prdata_nxt = '0;
            pms_pkg::PMS_PERCFG_ADDR: begin
               prdata_nxt[pms_pkg::PMS_PER_RXF_BIT] = rxf_r;
               prdata_nxt[pms_pkg::PMS_PER_SRC_BIT] = !batt_r;
            end
            pms_pkg::PMS_WAKE_ADDR: prdata_nxt[7:0] = wake_r;
            pms_pkg::PMS_SWO_ADDR: prdata_nxt[1:0] = swo_r;
            pms_pkg::PMS_STAT_ADDR: begin
               prdata_nxt[1:0] = mode_r;
               prdata_nxt[2] = afe_r;
               prdata_nxt[3] = sup.dc_low;
            end
            pms_pkg::PMS_LCD_ADDR: prdata_nxt[0] = lcd_r;
            default: begin
               pslverr_nxt = 1'b1;
               for (int i = 0; i < pms_pkg::PMS_NSCRATCH; i++) begin
                  if (paddr == pms_pkg::PMS_SCR0_ADDR + 8'(4 * i)) begin
                     prdata_nxt = scr_r[i];
                     pslverr_nxt = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= pms_pkg::PMS_FULL;
         wake_r <= '0;
         swo_r <= 2'h1;
         rxf_r <= 1'b0;
         lcd_r <= 1'b0;
         for (int i = 0; i < pms_pkg::PMS_NSCRATCH; i++) scr_r[i] <= '0;
         prev_r <= 4'hf;
         dc_cnt_r <= '0;
         core_run_r <= 1'b1;
         core_rst_r <= 1'b0;
         afe_r <= 1'b1;
         batt_r <= 1'b0;
         prdata_r <= '0;
         pslverr_r <= 1'b0;
         pready_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         wake_r <= wake_nxt;
         swo_r <= swo_nxt;
         rxf_r <= rxf_nxt;
         lcd_r <= lcd_nxt;
         scr_r <= scr_nxt;
         prev_r <= pin_s[3:0];
         dc_cnt_r <= dc_cnt_nxt;
         core_run_r <= core_run_nxt;
         core_rst_r <= core_rst_nxt;
         afe_r <= afe_nxt;
         batt_r <= batt_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         pready_r <= pready_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from flops
   // ------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rail_to_battery = batt_r;
   assign core_run = core_run_r;
   assign core_reset = core_rst_r;
   assign afe_enable = afe_r;
   assign lcd_enable = lcd_r;
   assign mode = mode_r;
endmodule : pms_sequencer
`default_nettype wire

// [verif/pms_properties.sv]
// Port-level checker for the power mode sequencer
`default_nettype none
module pms_properties #(
   parameter int LOWDC_CYCLES = 20
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Pins and supply status
   input wire logic ext_reset_n,
   input wire logic main_supply_ok,
   input wire logic dc_input_low,
   // Watched outputs
   input wire logic rail_to_battery,
   input wire logic core_run,
   input wire logic core_reset,
   input wire logic afe_enable,
   input wire logic [1:0] mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------
   // Low DC timer shadow
   // ------
   logic swo_wr; // Switchover word written
   logic en_r, en_nxt; // Switch on low DC armed
   logic [31:0] cnt_r, cnt_nxt; // Armed low DC cycles in full
   assign swo_wr = psel && penable && pready && pwrite
      && paddr == pms_pkg::PMS_SWO_ADDR;
   // Raw pin time, so the figure includes the sync delay
   always_comb begin
      en_nxt = swo_wr ? pwdata[pms_pkg::PMS_SWO_LOWDC_BIT] : en_r;
      cnt_nxt = (en_r && dc_input_low && mode == 2'h0) ? cnt_r + 32'h1
         : 32'h0;
   end
   // Registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
         cnt_r <= 32'h0;
      end else begin
         en_r <= en_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // ------
   // Properties
   // ------
   property p_sleep_core; mode == 2'h2 |-> !core_run; endproperty
   a_sleep_core: assert property (p_sleep_core)
      else $error("core running in sleep");
   property p_no_direct; mode == 2'h0 |=> mode != 2'h2; endproperty
   a_no_direct: assert property (p_no_direct)
      else $error("sleep entered from full");
   property p_batt_afe; mode == 2'h1 |-> !afe_enable; endproperty
   a_batt_afe: assert property (p_batt_afe)
      else $error("front end on in battery");
   property p_rail_mode; $rose(rail_to_battery) |-> ##[0:1] mode == 2'h1;
   endproperty
   a_rail_mode: assert property (p_rail_mode)
      else $error("switchover without battery mode");
   property p_wake_rst; mode == 2'h1 && $past(mode) == 2'h2
      |-> ##[0:1] core_reset; endproperty
   a_wake_rst: assert property (p_wake_rst)
      else $error("battery wake without restart");
   property p_main_wake; mode == 2'h0 && $past(mode) == 2'h2
      |-> afe_enable ##[0:1] core_reset; endproperty
   a_main_wake: assert property (p_main_wake)
      else $error("supply wake without restart");
   property p_batt_full; mode == 2'h0 && $past(mode) == 2'h1
      |-> afe_enable && core_run && !core_reset; endproperty
   a_batt_full: assert property (p_batt_full)
      else $error("battery to full handled wrongly");
   property p_rail_main; $fell(rail_to_battery) |-> ##[0:1] mode == 2'h0;
   endproperty
   a_rail_main: assert property (p_rail_main)
      else $error("rail on main without full mode");
   property p_reset_pin; mode == 2'h2 && $fell(ext_reset_n)
      && !main_supply_ok |-> ##[1:6] mode == 2'h1; endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset pin did not wake");
   property p_lowdc; $rose(rail_to_battery) && main_supply_ok
      |-> cnt_r >= LOWDC_CYCLES && cnt_r <= LOWDC_CYCLES + 8; endproperty
   a_lowdc: assert property (p_lowdc)
      else $error("low DC switchover time wrong");
endmodule : pms_properties
bind pms_sequencer pms_properties #(.LOWDC_CYCLES(LOWDC_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .ext_reset_n(ext_reset_n), .main_supply_ok(main_supply_ok),
   .dc_input_low(dc_input_low), .rail_to_battery(rail_to_battery),
   .core_run(core_run), .core_reset(core_reset),
   .afe_enable(afe_enable), .mode(mode));
`default_nettype wire

// [verif/pms_supply_model.sv]
// Behavioural model of the supply switchover circuitry
`default_nettype none
module pms_supply_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench commands
   input wire logic want_main,
   input wire logic want_dc_low,
   input wire logic slow,
   // Status towards the sequencer
   output var pms_pkg::pms_supply_t sup
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] main_r, main_nxt; // Main supply settling pipe
   logic dc_r, dc_nxt; // Low DC comparator
   // Shift the commanded levels along
   always_comb begin
      main_nxt = {main_r[2:0], want_main};
      dc_nxt = want_dc_low;
   end
   // Starts on a good main supply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_r <= 4'hf;
         dc_r <= 1'b0;
      end else begin
         main_r <= main_nxt;
         dc_r <= dc_nxt;
      end
   end
   // A slow supply settles in four cycles, a prompt one in one
   assign sup = {slow ? main_r[3] : main_r[0], dc_r};
endmodule : pms_supply_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the power mode sequencer
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LOWDC = 20; // Shortened low DC count
   // ------
   // Signals
   // ------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic ext_irq_a_n = 1'b1, ext_irq_b_n = 1'b1, rx_line = 1'b1;
   logic ext_reset_n = 1'b1, want_main = 1'b1, want_dc_low = 1'b0;
   logic slow = 1'b0, rail_to_battery, core_run, core_reset;
   logic afe_enable, lcd_enable;
   logic [1:0] mode;
   pms_pkg::pms_supply_t sup; // Supply status from the model
   logic [31:0] scr [4]; // Scratch words written
   int mismatches = 0, n_checks = 0, seed = 58, resets = 0, r0, n;
   pms_supply_model u_sup (.pclk(pclk), .presetn(presetn),
      .want_main(want_main), .want_dc_low(want_dc_low), .slow(slow),
      .sup(sup));
   pms_sequencer #(.LOWDC_CYCLES(LOWDC)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_a_n(ext_irq_a_n),
      .ext_irq_b_n(ext_irq_b_n), .rx_line(rx_line),
      .ext_reset_n(ext_reset_n), .main_supply_ok(sup.main_ok),
      .dc_input_low(sup.dc_low), .rail_to_battery(rail_to_battery),
      .core_run(core_run), .core_reset(core_reset),
      .afe_enable(afe_enable), .lcd_enable(lcd_enable), .mode(mode));
   // Clock and restart pulse counter
   always #20 pclk = ~pclk;
   always @(posedge pclk) if (core_reset === 1'b1) resets <= resets + 1;
   // ------
   // Expectations and helpers
   // ------
   function automatic logic [31:0] stat_exp(logic [1:0] m, logic afe);
      return {29'h0, afe, m};
   endfunction : stat_exp
   function automatic logic [31:0] per_exp(logic main, logic rxf);
      return {24'h0, rxf, main, 6'h0};
   endfunction : per_exp
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Hang guard: counted, then straight to the report
   task automatic fail(string msg);
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
      wrap_up();
   endtask : fail
   task automatic tick(int k);
      repeat (k) @(posedge pclk);
   endtask : tick
   // One bus transfer; request held until pready is sampled
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) fail("bus wait timed out");
   endtask : apb
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
      chk({31'h0, err}, 32'h0);
   endtask : rd
   task automatic wait_mode(logic [1:0] m);
      n = 0;
      while (mode !== m && n < 200) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 200) fail("mode wait timed out");
   endtask : wait_mode
   // ------
   // Main sequence
   // ------
   initial begin
      tick(8);
      presetn <= 1'b1;
      rd(pms_pkg::PMS_PERCFG_ADDR, per_exp(1'b1, 1'b0));
      rd(pms_pkg::PMS_STAT_ADDR, stat_exp(2'h0, 1'b1));
      // On main at power-up: low main switchover armed
      rd(pms_pkg::PMS_SWO_ADDR, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk({31'h0, err}, 32'h1);
      foreach (scr[i]) begin
         scr[i] = $random(seed);
         wr(pms_pkg::PMS_SCR0_ADDR + 8'(4 * i), scr[i]);
      end
      wr(pms_pkg::PMS_LCD_ADDR, 32'h1);
      // A edge rising, B select 111 falling, receive select 11
      wr(pms_pkg::PMS_WAKE_ADDR, 32'hfd);
      wr(pms_pkg::PMS_POWCTL_ADDR, 32'h10);
      tick(4);
      chk({30'h0, mode}, 32'h0);
      want_main <= 1'b0;
      wait_mode(2'h1);
      chk({31'h0, rail_to_battery}, 32'h1);
      chk({31'h0, afe_enable}, 32'h0);
      rd(pms_pkg::PMS_STAT_ADDR, stat_exp(2'h1, 1'b0));
      rd(pms_pkg::PMS_PERCFG_ADDR, per_exp(1'b0, 1'b0));
      // Each wake source in turn
      for (int k = 0; k < 4; k++) begin
         r0 = resets;
         wr(pms_pkg::PMS_POWCTL_ADDR, 32'h10);
         wait_mode(2'h2);
         chk({31'h0, core_run}, 32'h0);
         chk({31'h0, lcd_enable}, 32'h1);
         case (k)
            0: ext_reset_n <= 1'b0;
            1: begin
               ext_irq_a_n <= 1'b0;
               tick(8);
               chk({30'h0, mode}, 32'h2);
               ext_irq_a_n <= 1'b1;
            end
            2: ext_irq_b_n <= 1'b0;
            default: rx_line <= 1'b0;
         endcase
         wait_mode(2'h1);
         tick(2);
         chk(32'(resets - r0), 32'h1);
         ext_reset_n <= 1'b1;
         ext_irq_b_n <= 1'b1;
         rx_line <= 1'b1;
         rd(pms_pkg::PMS_PERCFG_ADDR, per_exp(1'b0, k == 3));
         wr(pms_pkg::PMS_PERCFG_ADDR, 32'h80);
      end
      rd(pms_pkg::PMS_PERCFG_ADDR, per_exp(1'b0, 1'b0));
      foreach (scr[i]) rd(pms_pkg::PMS_SCR0_ADDR + 8'(4 * i), scr[i]);
      rd(pms_pkg::PMS_LCD_ADDR, 32'h1);
      // Supply returns in sleep, then in battery
      wr(pms_pkg::PMS_POWCTL_ADDR, 32'h10);
      wait_mode(2'h2);
      r0 = resets;
      want_main <= 1'b1;
      wait_mode(2'h0);
      tick(2);
      chk(32'(resets - r0), 32'h1);
      chk({31'h0, rail_to_battery}, 32'h0);
      chk({31'h0, afe_enable}, 32'h1);
      rd(pms_pkg::PMS_PERCFG_ADDR, per_exp(1'b1, 1'b0));
      slow <= 1'b1;
      want_main <= 1'b0;
      wait_mode(2'h1);
      r0 = resets;
      want_main <= 1'b1;
      wait_mode(2'h0);
      tick(2);
      chk(32'(resets - r0), 32'h0);
      rd(pms_pkg::PMS_STAT_ADDR, stat_exp(2'h0, 1'b1));
      slow <= 1'b0;
      r0 = resets;
      wr(pms_pkg::PMS_POWCTL_ADDR, 32'h1);
      tick(3);
      chk(32'(resets - r0), 32'h1);
      // Low DC switchover armed by software after backup
      wr(pms_pkg::PMS_SWO_ADDR, 32'h3);
      want_dc_low <= 1'b1;
      wait_mode(2'h1);
      chk({31'h0, n >= LOWDC && n <= LOWDC + 8}, 32'h1);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
